// File: rtl/fsi_regs.svh
`ifndef FSI_REGS_SVH
`define FSI_REGS_SVH
// register byte offsets
`define FSI_OFF_PEND 5'h00
`define FSI_OFF_ACK 5'h04
`define FSI_OFF_PRMANS 5'h08
`define FSI_OFF_PRMINFO 5'h0c
`define FSI_OFF_GC 5'h10
`define FSI_OFF_CTRL 5'h14
// indication bit positions
`define FSI_IND_DXCHG 0
`define FSI_IND_OFFLINE 1
`define FSI_IND_BAUD 2
`define FSI_IND_WDOG 3
`define FSI_IND_TICK 4
`define FSI_IND_GC 5
`define FSI_IND_ADDR 6
`define FSI_IND_CFG 7
`define FSI_IND_PRM 8
`define FSI_IND_DIAG 9
`define FSI_IND_DOUT 10
// parameter answer codes and results
`define FSI_ANS_ACCEPT 2'h1
`define FSI_ANS_REJECT 2'h2
`define FSI_RES_NONE 2'h0
`define FSI_RES_DONE 2'h1
`define FSI_RES_CONFLICT 2'h2
`define FSI_RES_FORBID 2'h3
// tick period
`define FSI_TICK_NS 100000
`define FSI_CLK_NS 8
`define FSI_TICK_CYC (`FSI_TICK_NS / `FSI_CLK_NS)
`endif

// File: rtl/fsi_pkg.sv
package fsi_pkg;
    typedef struct packed {
        logic dx_enter;
        logic dx_leave;
        logic offline_done;
        logic baud_found;
        logic wdog_expired;
        logic prm_msg;
        logic cfg_msg;
        logic addr_msg;
        logic gc_msg;
        logic [7:0] gc_byte;
        logic diag_swapped;
        logic dout_new;
        logic dout_cleared;
        logic [7:0] prm_len;
        logic [7:0] prm_buf_loc;
    } fsi_events_t;
endpackage : fsi_pkg

// File: rtl/fsi_indication.sv
`timescale 1ns/1ns
`include "fsi_regs.svh"
// Overview of operation
// RL1: host polls or takes interrupt, its choice
// RL2: whole word poll uses interrupt layout
// RL3: sixteen bit field, one bit each
// RL4: one acknowledge clears polled or signalled
// RL5: data exchange entry or exit indicates
// RL6: offline after request, then indicate
// RL7: baud found indicates
// RL8: watchdog expiry in control state indicates
// RL9: tick indication every tenth millisecond
// RL10: changed global command stored, indicated
// RL11: address, config, parameter messages indicate
// RL12: diagnostics swap indicates
// RL13: output data, power-on, departure indicate
// RL14: parameter length and buffer readable
// RL15: accept or reject clears parameter indication
// RL16: reject marks parameters unusable (code leaves prm_usable unchanged when bus_mode_forbid is set)
// RL17: no new message gives done
// RL18: newer message gives conflict
// RL19: forbidden bus mode gives forbidden
// RL20: host checks parameters before config
// RL21: bits stay until acknowledged or answered
module fsi_indication #(
    parameter int TICK_CYCLES = `FSI_TICK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // protocol events from the slave engine
    input wire fsi_pkg::fsi_events_t events,
    input wire logic bus_mode_forbid,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // host signalling
    output logic irq,
    output logic prm_usable,
    output logic go_offline_req
);
    import fsi_pkg::*;

    // RL3: sixteen bit pending field
    logic [15:0] pend;
    logic [15:0] ind_enable;
    logic [15:0] next_pend;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [7:0] gc_cell;
    logic [1:0] prm_result;
    logic prm_newer;
    logic ack_pulse;
    logic [31:0] tick_cnt;
    logic tick;
    logic wr_hit;
    logic rd_hit;
    logic rd_cap;
    logic prm_ans;
    logic [1:0] ans_code;

    // one wait cycle per access, answer on the second edge
    assign wr_hit = avs_write && !avs_waitrequest;
    assign rd_hit = avs_read && !avs_waitrequest;
    assign prm_ans = wr_hit && avs_address == `FSI_OFF_PRMANS;
    assign ans_code = avs_writedata[1:0];
    // read data captured in the wait cycle, standing at the taking edge
    assign rd_cap = avs_read && avs_waitrequest;

    // waitrequest from a flop, so the host sees a clean level
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write)
                                 && avs_waitrequest);
        end
    end

    // RL9: tenth millisecond tick
    always_ff @(posedge clk) begin
        if (reset || tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end
    assign tick = tick_cnt == TICK_CYCLES - 1;

    // RL10: store only a changed command byte
    always_ff @(posedge clk) begin
        if (reset) begin
            gc_cell <= 8'h00;
        end else if (events.gc_msg && events.gc_byte != gc_cell) begin
            gc_cell <= events.gc_byte;
        end
    end

    always_comb begin
        set_vec = 16'h0000;
        // RL5: data exchange edges
        set_vec[`FSI_IND_DXCHG] = events.dx_enter || events.dx_leave;
        // RL6: offline reached
        set_vec[`FSI_IND_OFFLINE] = events.offline_done;
        // RL7: baud rate found
        set_vec[`FSI_IND_BAUD] = events.baud_found;
        // RL8: watchdog expiry
        set_vec[`FSI_IND_WDOG] = events.wdog_expired;
        // RL9: periodic tick
        set_vec[`FSI_IND_TICK] = tick;
        // RL10: changed command byte
        set_vec[`FSI_IND_GC] = events.gc_msg && events.gc_byte != gc_cell;
        // RL11: message arrival bits
        set_vec[`FSI_IND_ADDR] = events.addr_msg;
        set_vec[`FSI_IND_CFG] = events.cfg_msg;
        set_vec[`FSI_IND_PRM] = events.prm_msg;
        // RL12: diagnostics swap
        set_vec[`FSI_IND_DIAG] = events.diag_swapped;
        // RL13: output data new or cleared
        set_vec[`FSI_IND_DOUT] = events.dout_new || events.dout_cleared;
        set_vec = set_vec & ind_enable;
    end

    always_comb begin
        clr_vec = 16'h0000;
        // RL4: one acknowledge for polled or signalled
        if (wr_hit && avs_address == `FSI_OFF_ACK) begin
            clr_vec = avs_writedata[15:0];
            // RL15: parameter bit is owned by the answer
            clr_vec[`FSI_IND_PRM] = 1'b0;
        end
        if (prm_ans && (ans_code == `FSI_ANS_ACCEPT
                        || ans_code == `FSI_ANS_REJECT)) begin
            clr_vec[`FSI_IND_PRM] = 1'b1;
        end
    end

    // RL21: sticky until cleared, set wins
    assign next_pend = (pend & ~clr_vec) | set_vec;
    always_ff @(posedge clk) begin
        if (reset) begin
            pend <= 16'h0000;
        end else begin
            pend <= next_pend;
        end
    end

    // RL1: interrupt is a registered or of pending
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |next_pend;
        end
    end

    // newer parameter message during the check
    always_ff @(posedge clk) begin
        if (reset) begin
            prm_newer <= 1'b0;
        end else if (prm_ans) begin
            prm_newer <= events.prm_msg;
        end else if (events.prm_msg && pend[`FSI_IND_PRM]) begin
            prm_newer <= 1'b1;
        end
    end

    // RL17: done / RL18: conflict / RL19: forbidden
    always_ff @(posedge clk) begin
        if (reset) begin
            prm_result <= `FSI_RES_NONE;
        end else if (prm_ans) begin
            if (bus_mode_forbid) begin
                prm_result <= `FSI_RES_FORBID;
            end else if (prm_newer || events.prm_msg) begin
                prm_result <= `FSI_RES_CONFLICT;
            end else begin
                prm_result <= `FSI_RES_DONE;
            end
        end
    end

    // RL16: reject blocks adoption, except in forbidden bus mode where prm_usable keeps its value
    always_ff @(posedge clk) begin
        if (reset) begin
            prm_usable <= 1'b0;
        end else if (prm_ans && !bus_mode_forbid) begin
            prm_usable <= ans_code == `FSI_ANS_ACCEPT;
        end else if (events.prm_msg) begin
            prm_usable <= 1'b0;
        end
    end

    // control: offline request and indication enables
    always_ff @(posedge clk) begin
        if (reset) begin
            go_offline_req <= 1'b0;
            ind_enable <= 16'hffff;
        end else if (wr_hit && avs_address == `FSI_OFF_CTRL) begin
            go_offline_req <= avs_writedata[16];
            ind_enable <= avs_writedata[15:0];
        end else if (events.offline_done) begin
            // RL6: request finished
            go_offline_req <= 1'b0;
        end
    end

    // RL2: whole word poll, same layout
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_cap) begin
            if (avs_address == `FSI_OFF_PEND) begin
                avs_readdata <= {16'h0000, pend};
            end else if (avs_address == `FSI_OFF_PRMANS) begin
                avs_readdata <= {30'h0000_0000, prm_result};
            end else if (avs_address == `FSI_OFF_PRMINFO) begin
                // RL14: length and buffer location
                avs_readdata <= {16'h0000, events.prm_buf_loc,
                                 events.prm_len};
            end else if (avs_address == `FSI_OFF_GC) begin
                avs_readdata <= {24'h00_0000, gc_cell};
            end else if (avs_address == `FSI_OFF_CTRL) begin
                avs_readdata <= {15'h0000, go_offline_req, ind_enable};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    a_set_wins: assert property (@(posedge clk) disable iff (reset)
        set_vec[`FSI_IND_DXCHG] |=> pend[`FSI_IND_DXCHG]) // RL5
        else $error("data exchange indication lost");
    a_sticky_bits: assert property (@(posedge clk) disable iff (reset)
        pend[`FSI_IND_BAUD] && !clr_vec[`FSI_IND_BAUD]
        |=> pend[`FSI_IND_BAUD]) // RL21
        else $error("indication dropped without clear");
    a_ack_clears: assert property (@(posedge clk) disable iff (reset)
        wr_hit && avs_address == `FSI_OFF_ACK && avs_writedata[3]
        && !set_vec[3] |=> !pend[3]) // RL4
        else $error("acknowledge did not clear");
    a_ack_keeps_prm: assert property (@(posedge clk) disable iff (reset)
        pend[8] && wr_hit && avs_address == `FSI_OFF_ACK |=> pend[8]) // RL15
        else $error("general acknowledge cleared parameter bit");
    a_reject_unusable: assert property (@(posedge clk) disable iff (reset)
        prm_ans && ans_code == `FSI_ANS_REJECT |=> !prm_usable) // RL16
        else $error("rejected parameters usable");
    a_forbid_result: assert property (@(posedge clk) disable iff (reset)
        prm_ans && bus_mode_forbid
        |=> prm_result == `FSI_RES_FORBID) // RL19
        else $error("forbidden result missing");
    a_conflict_result: assert property (@(posedge clk) disable iff (reset)
        prm_ans && !bus_mode_forbid && prm_newer
        |=> prm_result == `FSI_RES_CONFLICT) // RL18
        else $error("conflict result missing");
    a_done_result: assert property (@(posedge clk) disable iff (reset)
        prm_ans && !bus_mode_forbid && !prm_newer && !events.prm_msg
        |=> prm_result == `FSI_RES_DONE) // RL17
        else $error("done result missing");
    a_irq_follows: assert property (@(posedge clk) disable iff (reset)
        irq == (pend != 16'h0000)) // RL1
        else $error("interrupt disagrees with pending");
    a_tick_period: assert property (@(posedge clk) disable iff (reset)
        tick |=> !tick [*2]) // RL9
        else $error("tick too frequent");
    a_gc_store: assert property (@(posedge clk) disable iff (reset)
        set_vec[`FSI_IND_GC] |=> gc_cell == $past(events.gc_byte)) // RL10
        else $error("command byte not stored");
    a_poll_layout: assert property (@(posedge clk) disable iff (reset)
        rd_cap && avs_address == `FSI_OFF_PEND
        |=> avs_readdata[15:0] == $past(pend)) // RL2
        else $error("poll word mismatch");

    // bus handshake: one wait cycle, then back to waiting
    a_wait_answer: assert property (@(posedge clk) disable iff (reset)
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) // RL1
        else $error("waitrequest did not drop");

    a_wait_release: assert property (@(posedge clk) disable iff (reset)
        !avs_waitrequest |=> avs_waitrequest) // RL1
        else $error("waitrequest stayed low");

    a_result_read: assert property (@(posedge clk) disable iff (reset)
        rd_cap && avs_address == `FSI_OFF_PRMANS
        |=> avs_readdata[1:0] == $past(prm_result)) // RL17
        else $error("result read mismatch");

    a_info_read: assert property (@(posedge clk) disable iff (reset)
        rd_cap && avs_address == `FSI_OFF_PRMINFO
        |=> avs_readdata[15:0] == {$past(events.prm_buf_loc),
                                   $past(events.prm_len)}) // RL14
        else $error("parameter info mismatch");

    a_gc_read: assert property (@(posedge clk) disable iff (reset)
        rd_cap && avs_address == `FSI_OFF_GC
        |=> avs_readdata[7:0] == $past(gc_cell)) // RL10
        else $error("command cell read mismatch");

    // event bits land in the pending field
    a_offline_set: assert property (@(posedge clk) disable iff (reset)
        events.offline_done && ind_enable[`FSI_IND_OFFLINE]
        |=> pend[`FSI_IND_OFFLINE]) // RL6
        else $error("offline indication missing");

    a_offline_req: assert property (@(posedge clk) disable iff (reset)
        events.offline_done && !(wr_hit && avs_address == `FSI_OFF_CTRL)
        |=> !go_offline_req) // RL6
        else $error("offline request not finished");

    a_baud_set: assert property (@(posedge clk) disable iff (reset)
        events.baud_found && ind_enable[`FSI_IND_BAUD]
        |=> pend[`FSI_IND_BAUD]) // RL7
        else $error("baud indication missing");

    a_wdog_set: assert property (@(posedge clk) disable iff (reset)
        events.wdog_expired && ind_enable[`FSI_IND_WDOG]
        |=> pend[`FSI_IND_WDOG]) // RL8
        else $error("watchdog indication missing");

    a_addr_set: assert property (@(posedge clk) disable iff (reset)
        events.addr_msg && ind_enable[`FSI_IND_ADDR]
        |=> pend[`FSI_IND_ADDR]) // RL11
        else $error("address indication missing");

    a_diag_set: assert property (@(posedge clk) disable iff (reset)
        events.diag_swapped && ind_enable[`FSI_IND_DIAG]
        |=> pend[`FSI_IND_DIAG]) // RL12
        else $error("diagnostics indication missing");

    a_dout_set: assert property (@(posedge clk) disable iff (reset)
        (events.dout_new || events.dout_cleared)
        && ind_enable[`FSI_IND_DOUT] |=> pend[`FSI_IND_DOUT]) // RL13
        else $error("output data indication missing");

    // a masked cause never shows up
    a_mask_blocks: assert property (@(posedge clk) disable iff (reset)
        !ind_enable[`FSI_IND_DXCHG] && !pend[`FSI_IND_DXCHG]
        |=> !pend[`FSI_IND_DXCHG]) // RL3
        else $error("masked indication raised");

    // parameter answer handling
    a_accept_usable: assert property (@(posedge clk) disable iff (reset)
        prm_ans && ans_code == `FSI_ANS_ACCEPT && !bus_mode_forbid
        |=> prm_usable) // RL16
        else $error("accepted parameters unusable");

    a_answer_clears: assert property (@(posedge clk) disable iff (reset)
        prm_ans && (ans_code == `FSI_ANS_ACCEPT
                    || ans_code == `FSI_ANS_REJECT) && !events.prm_msg
        |=> !pend[`FSI_IND_PRM]) // RL15
        else $error("answer left parameter bit");

    c_prm_accept: cover property (@(posedge clk)
        prm_ans && ans_code == `FSI_ANS_ACCEPT);
    c_prm_conflict: cover property (@(posedge clk)
        prm_result == `FSI_RES_CONFLICT);
    c_ack_write: cover property (@(posedge clk)
        wr_hit && avs_address == `FSI_OFF_ACK);
    c_offline: cover property (@(posedge clk) events.offline_done);
    c_prm_forbid: cover property (@(posedge clk)
        prm_result == `FSI_RES_FORBID);
endmodule : fsi_indication

// File: bench/fsi_engine_model.sv
`timescale 1ns/1ns
module fsi_engine_model #(
    parameter logic [7:0] PRM_LEN = 8'h0c,
    parameter logic [7:0] PRM_LOC = 8'h40
) (
    // clock
    input wire logic clk,
    // bench requests, one bit per event kind
    input wire logic [11:0] pulse,
    input wire logic [7:0] gc_val,
    // event bundle to the block
    output fsi_pkg::fsi_events_t events
);
    import fsi_pkg::*;
    // registered, so each event follows its request one cycle later
    always_ff @(posedge clk) begin
        events <= '{pulse[0], pulse[4], pulse[1], pulse[2], pulse[3],
            pulse[8], pulse[7], pulse[6], pulse[5], gc_val, pulse[9],
            pulse[10], pulse[11], PRM_LEN, PRM_LOC};
    end
endmodule : fsi_engine_model

// File: bench/tb_fieldbus_slave_indication_unit.sv
`timescale 1ns/1ns
`include "fsi_regs.svh"
module tb_fieldbus_slave_indication_unit;
    logic clk, reset, forbid, avs_read, avs_write, avs_waitrequest;
    logic irq, prm_usable, go_offline_req;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [11:0] pulse;
    logic [7:0] gc_val;
    fsi_pkg::fsi_events_t events;
    int checks = 0;
    int n_mismatch = 0;
    int cyc = 0;

    fsi_engine_model i_fsi_engine_model (.clk(clk), .pulse(pulse),
        .gc_val(gc_val), .events(events));
    fsi_indication #(.TICK_CYCLES(8)) i_fsi_indication (.clk(clk),
        .reset(reset), .events(events), .bus_mode_forbid(forbid),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .prm_usable(prm_usable),
        .go_offline_req(go_offline_req));

    always #4 clk = ~clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // a hung handshake ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    function automatic logic [15:0] ind_of(input int k);
        case (k)
            4: ind_of = 16'h0001;
            11: ind_of = 16'h0400;
            default: ind_of = 16'h0001 << k;
        endcase
    endfunction : ind_of

    task automatic chk(input string s, input logic [31:0] e,
            input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] a,
            input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [31:0] e,
            input string s);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(s, e, q);
    endtask : rdc

    task automatic fire(input logic [11:0] p);
        pulse <= p;
        @(posedge clk);
        pulse <= '0;
        repeat (3) @(posedge clk);
    endtask : fire

    initial begin
        int k, st;
        logic [11:0] p;
        logic [15:0] m;
        clk = 1'b0;
        reset = 1'b1;
        forbid = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        pulse = '0;
        void'($urandom(32'hee6f28be));
        gc_val = 8'($urandom) | 8'h01;
        st = int'($urandom % 12);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdc(`FSI_OFF_CTRL, 32'h0000_ffff, "ctrl");
        rdc(`FSI_OFF_GC, 32'h0000_0000, "gc cell");
        // tick runs from reset: mask it and drop what it raised
        wr(`FSI_OFF_CTRL, 32'h0000_ffef);
        wr(`FSI_OFF_ACK, 32'h0000_0010);
        wr(`FSI_OFF_PEND, 32'hffff_ffff);
        rdc(`FSI_OFF_PEND, 32'h0000_0000, "pend");
        wr(5'h18, 32'hffff_ffff);
        rdc(5'h18, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 12; i++) begin
            k = (i + st) % 12;
            if (k == 8) continue;
            fire(12'h001 << k);
            rdc(`FSI_OFF_PEND, 32'(ind_of(k)), "pend");
            chk("irq", 32'h0000_0001, 32'(irq));
            wr(`FSI_OFF_ACK, 32'(ind_of(k)));
            rdc(`FSI_OFF_PEND, 32'h0000_0000, "pend");
        end
        rdc(`FSI_OFF_GC, 32'(gc_val), "gc cell");
        // same command byte again must stay quiet
        fire(12'h020);
        rdc(`FSI_OFF_PEND, 32'h0000_0000, "gc same");
        repeat (3) begin
            p = 12'($urandom) & 12'hedf;
            m = '0;
            for (int b = 0; b < 12; b++) if (p[b]) m |= ind_of(b);
            fire(p);
            rdc(`FSI_OFF_PEND, 32'(m), "pend word");
            wr(`FSI_OFF_ACK, 32'(m));
        end
        fire(12'h180);
        rdc(`FSI_OFF_PRMINFO, 32'h0000_400c, "prm info");
        wr(`FSI_OFF_ACK, 32'h0000_0100);
        rdc(`FSI_OFF_PEND, 32'h0000_0180, "ack bit8");
        wr(`FSI_OFF_PRMANS, `FSI_ANS_ACCEPT);
        rdc(`FSI_OFF_PRMANS, `FSI_RES_DONE, "result");
        rdc(`FSI_OFF_PEND, 32'h0000_0080, "pend");
        chk("usable", 32'h0000_0001, 32'(prm_usable));
        wr(`FSI_OFF_ACK, 32'h0000_0080);
        fire(12'h100);
        fire(12'h100);
        wr(`FSI_OFF_PRMANS, `FSI_ANS_REJECT);
        rdc(`FSI_OFF_PRMANS, `FSI_RES_CONFLICT, "result");
        chk("usable", 32'h0000_0000, 32'(prm_usable));
        fire(12'h100);
        forbid <= 1'b1;
        wr(`FSI_OFF_PRMANS, `FSI_ANS_ACCEPT);
        rdc(`FSI_OFF_PRMANS, `FSI_RES_FORBID, "result");
        chk("usable", 32'h0000_0000, 32'(prm_usable));
        rdc(`FSI_OFF_PEND, 32'h0000_0000, "pend");
        forbid <= 1'b0;
        wr(`FSI_OFF_CTRL, 32'h0000_ffff);
        repeat (12) @(posedge clk);
        rdc(`FSI_OFF_PEND, 32'h0000_0010, "tick");
        wr(`FSI_OFF_CTRL, 32'h0001_ffef);
        wr(`FSI_OFF_ACK, 32'h0000_0010);
        chk("offline req", 32'h0000_0001, 32'(go_offline_req));
        fire(12'h002);
        chk("offline req", 32'h0000_0000, 32'(go_offline_req));
        rdc(`FSI_OFF_PEND, 32'h0000_0002, "offline");
        wr(`FSI_OFF_ACK, 32'h0000_0002);
        wr(`FSI_OFF_CTRL, 32'h0000_ffee);
        fire(12'h001);
        rdc(`FSI_OFF_PEND, 32'h0000_0000, "masked");
        chk("irq", 32'h0000_0000, 32'(irq));
        test_done();
    end
endmodule : tb_fieldbus_slave_indication_unit
